//--- rtl/mia_portal.sv
/*
  Indirect-access portal: control register and address/data register that
  open a space of 32 devices by 65,536 words, plus a small local window of
  indirect registers for one device.
  Assumes a frame decoder that issues one access per strobe on the
  management clock, and that inputs are synchronous to that clock.
*/
`timescale 1ns/100ps

module mia_portal
  import mia_pkg::*;
#(
  parameter logic [MIA_DEV_W-1:0] MEM_DEV   = MIA_MEM_DEV_DEF,   // Device held locally
  parameter int unsigned          MEM_DEPTH = MIA_MEM_DEPTH_DEF  // Words held, at least 2
) (
  // Clock, reset and enable
  input  wire logic     clk_i,
  input  wire logic     nrst_i,
  input  wire logic     en_i,
  // Decoded management access and its answer
  input  wire mia_req_t req_i,
  output mia_rsp_t      rsp_o,
  // Portal state for the rest of the device
  output mia_op_t       op_o,
  output logic [MIA_DEV_W-1:0] dev_o,
  output logic [MIA_REG_W-1:0] reg_addr_o
);

  localparam int unsigned IDX_W = $clog2(MEM_DEPTH);

  // Splits an operation field out of a control word
  function automatic mia_op_t op_of(input logic [MIA_REG_W-1:0] ctrl);
    op_of = mia_op_t'(ctrl[MIA_OP_HI:MIA_OP_LO]);
  endfunction : op_of

  // True for any operation that moves register contents, not the address
  function automatic logic is_data(input mia_op_t op);
    is_data = (op != MIA_OP_ADDR);
  endfunction : is_data

  // Portal state
  logic [MIA_REG_W-1:0] ctrl_r;
  logic [MIA_REG_W-1:0] ctrl_nxt;
  logic [MIA_REG_W-1:0] addr_r;
  logic [MIA_REG_W-1:0] addr_nxt;
  mia_rsp_t             rsp_r;
  mia_rsp_t             rsp_nxt;

  // Local indirect window
  logic [MIA_REG_W-1:0] mem_r [MEM_DEPTH];
  logic                 mem_we;
  logic [IDX_W-1:0]     mem_idx;

  // Decode of the current access
  mia_op_t              op;
  logic [MIA_DEV_W-1:0] dev;
  logic                 hit_ctrl;
  logic                 hit_data;
  logic                 mapped;
  logic                 do_inc;
  logic [MIA_REG_W-1:0] ind_rdata;

  assign op       = op_of(ctrl_r);
  assign dev      = ctrl_r[MIA_DEV_HI:MIA_DEV_LO];
  assign hit_ctrl = en_i && req_i.acc && (req_i.addr == MIA_CTRL_ADDR);
  assign hit_data = en_i && req_i.acc && (req_i.addr == MIA_DATA_ADDR);
  assign mem_idx  = addr_r[IDX_W-1:0];
  // Only the local device and its low words exist; the rest of the 32 by
  // 65,536 space answers as empty rather than stalling the host.
  assign mapped   = (dev == MEM_DEV) && (32'(addr_r) < MEM_DEPTH);
  assign ind_rdata = mapped ? mem_r[mem_idx] : MIA_ZERO;

  // Increment decision per operation and direction
  always_comb begin
    unique case (op)
      MIA_OP_INC_RW: do_inc = 1'b1;
      MIA_OP_INC_WR: do_inc = req_i.wr;
      MIA_OP_DATA:   do_inc = 1'b0;
      MIA_OP_ADDR:   do_inc = 1'b0;
    endcase
  end

  // Next portal state and answer
  always_comb begin
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    rsp_nxt  = rsp_r;
    mem_we   = 1'b0;
    if (en_i) begin
      rsp_nxt.ack = req_i.acc;
      if (req_i.acc && !req_i.wr) begin
        rsp_nxt.rdata = MIA_ZERO;
      end
    end
    if (hit_ctrl) begin
      if (req_i.wr) begin
        ctrl_nxt = req_i.wdata;
      end else begin
        rsp_nxt.rdata = ctrl_r;
      end
    end
    if (hit_data) begin
      if (!is_data(op)) begin
        if (req_i.wr) begin
          addr_nxt = req_i.wdata;
        end else begin
          rsp_nxt.rdata = addr_r;
        end
      end else begin
        if (req_i.wr) begin
          mem_we = mapped;
        end else begin
          rsp_nxt.rdata = ind_rdata;
        end
        if (do_inc) begin
          addr_nxt = addr_r + MIA_ADDR_STEP;
        end
      end
    end
  end

  // Register portal state; clock enable is folded into the next values
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= MIA_CTRL_RST;
      addr_r <= MIA_DATA_RST;
      rsp_r  <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      rsp_r  <= rsp_nxt;
    end
  end

  // Local window storage; reset clears it so reads are defined
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i] <= MIA_ZERO;
      end
    end else if (mem_we) begin
      mem_r[mem_idx] <= req_i.wdata;
    end
  end

  assign rsp_o      = rsp_r;
  assign op_o       = op;
  assign dev_o      = dev;
  assign reg_addr_o = addr_r;

  // Control write lands whole one edge later
  property p_ctrl_wr;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_ctrl && req_i.wr) |=> (ctrl_r == $past(req_i.wdata));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  // Address mode write stores the register address
  property p_addr_wr;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_data && req_i.wr && op == MIA_OP_ADDR) |=> (addr_r == $past(req_i.wdata));
  endproperty
  a_addr_wr: assert property (p_addr_wr) else $error("address not stored");

  // Address mode read answers with the stored address
  property p_addr_rd;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_data && !req_i.wr && op == MIA_OP_ADDR) |=>
        (rsp_o.ack && rsp_o.rdata == $past(addr_r));
  endproperty
  a_addr_rd: assert property (p_addr_rd) else $error("address readback wrong");

  // Every access taken while enable is high is answered exactly one edge later; while enable is low the
  // answer is frozen, so a high ack may stand through that cycle
  property p_ack;
    @(posedge clk_i) disable iff (!nrst_i)
      (en_i && req_i.acc) |=> rsp_o.ack ##1 (!rsp_o.ack || $past(req_i.acc || !en_i));
  endproperty
  a_ack: assert property (p_ack) else $error("answer timing wrong");

  // Increment on reads and writes
  property p_inc_rw;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_data && op == MIA_OP_INC_RW) |=> (addr_r == $past(addr_r) + MIA_ADDR_STEP);
  endproperty
  a_inc_rw: assert property (p_inc_rw) else $error("no increment in mode 10");

  // Writes-only increment: writes step
  property p_inc_wr;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_data && req_i.wr && op == MIA_OP_INC_WR) |=>
        (addr_r == $past(addr_r) + MIA_ADDR_STEP);
  endproperty
  a_inc_wr: assert property (p_inc_wr) else $error("no write increment in mode 11");

  // Writes-only increment: reads hold the address
  property p_hold_rd;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_data && !req_i.wr && op == MIA_OP_INC_WR) |=> $stable(addr_r);
  endproperty
  a_hold_rd: assert property (p_hold_rd) else $error("read moved address in mode 11");

  // Data read of a location outside the window answers zero
  property p_unmapped_rd;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_data && !req_i.wr && is_data(op) && !mapped) |=> (rsp_o.rdata == MIA_ZERO);
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

  // Data write, one idle cycle, then a plain data read returns the value; the
  // gap is the usual pace of a serial management host
  property p_data_rt;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_data && req_i.wr && op == MIA_OP_DATA && mapped) ##1 !req_i.acc ##1
        (hit_data && !req_i.wr && op == MIA_OP_DATA) |=>
        (rsp_o.rdata == $past(req_i.wdata, 3));
  endproperty
  a_data_rt: assert property (p_data_rt) else $error("data round trip wrong");

  // Reset leaves both portal registers at zero
  property p_reset;
    @(posedge clk_i)
      !nrst_i |=> (ctrl_r == MIA_CTRL_RST && addr_r == MIA_DATA_RST) || !nrst_i;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");

  // Control read answers the whole stored control word
  property p_ctrl_rd;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_ctrl && !req_i.wr) |=>
        (rsp_o.ack && rsp_o.rdata == $past(ctrl_r));
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");

  // Data path accesses never disturb the control word
  property p_ctrl_keep;
    @(posedge clk_i) disable iff (!nrst_i)
      hit_data |=>
        $stable(ctrl_r);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("control moved by data access");

  // Mode 01 leaves the stored address alone
  property p_data_hold;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_data && op == MIA_OP_DATA) |=> $stable(addr_r);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("address moved in mode 01");

  // Reads outside the two portal addresses answer zero
  property p_other_rd;
    @(posedge clk_i) disable iff (!nrst_i)
      (en_i && req_i.acc && !req_i.wr && !hit_ctrl && !hit_data) |=>
        (rsp_o.ack && rsp_o.rdata == MIA_ZERO);
  endproperty
  a_other_rd: assert property (p_other_rd) else $error("stray read not zero");

  // Writes outside the two portal addresses change no portal state
  property p_other_wr;
    @(posedge clk_i) disable iff (!nrst_i)
      (en_i && req_i.acc && req_i.wr && !hit_ctrl && !hit_data) |=>
        ($stable(ctrl_r) && $stable(addr_r));
  endproperty
  a_other_wr: assert property (p_other_wr) else $error("stray write changed state");

  // A data write aimed at another device leaves the local window alone
  property p_foreign_wr;
    @(posedge clk_i) disable iff (!nrst_i)
      (hit_data && req_i.wr && op == MIA_OP_DATA && dev != MEM_DEV) |=>
        $stable(mem_r[mem_idx]);
  endproperty
  a_foreign_wr: assert property (p_foreign_wr) else $error("foreign write reached window");

  // No answer without a taken access
  property p_ack_quiet;
    @(posedge clk_i) disable iff (!nrst_i)
      (en_i && !req_i.acc) |=> !rsp_o.ack;
  endproperty
  a_ack_quiet: assert property (p_ack_quiet) else $error("answer without access");

  // Writes leave the last read result standing
  property p_rdata_keep;
    @(posedge clk_i) disable iff (!nrst_i)
      (en_i && req_i.acc && req_i.wr) |=> $stable(rsp_o.rdata);
  endproperty
  a_rdata_keep: assert property (p_rdata_keep) else $error("write changed read data");

  // Enable low freezes the portal registers and the answer; a host that
  // drops enable right after an access sees that answer held, not cleared
  property p_freeze;
    @(posedge clk_i) disable iff (!nrst_i)
      !en_i |=> ($stable(ctrl_r) && $stable(addr_r) && $stable(rsp_o));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

endmodule : mia_portal

//--- rtl/mia_pkg.sv
/*
  Constants, field layout and carrier types for the indirect-access portal.
  Assumes a management frame decoder outside that presents one decoded
  register access per strobe, synchronous to the management clock.
*/
package mia_pkg;

  // Data and address widths of the direct management space
  localparam int unsigned MIA_REG_W  = 16;
  localparam int unsigned MIA_ADDR_W = 5;
  localparam int unsigned MIA_DEV_W  = 5;

  // Portal register addresses in the direct management space
  localparam logic [MIA_ADDR_W-1:0] MIA_CTRL_ADDR = 5'h0D;
  localparam logic [MIA_ADDR_W-1:0] MIA_DATA_ADDR = 5'h0E;

  // Field positions inside the access-control register
  localparam int unsigned MIA_OP_HI  = 15;
  localparam int unsigned MIA_OP_LO  = 14;
  localparam int unsigned MIA_DEV_HI = 4;
  localparam int unsigned MIA_DEV_LO = 0;

  // Reset values and the address step
  localparam logic [MIA_REG_W-1:0] MIA_CTRL_RST  = 16'h0000;
  localparam logic [MIA_REG_W-1:0] MIA_DATA_RST  = 16'h0000;
  localparam logic [MIA_REG_W-1:0] MIA_ADDR_STEP = 16'h0001;
  localparam logic [MIA_REG_W-1:0] MIA_ZERO      = 16'h0000;

  // Defaults for the locally held indirect register window
  localparam logic [MIA_DEV_W-1:0] MIA_MEM_DEV_DEF   = 5'h1F;
  localparam int unsigned          MIA_MEM_DEPTH_DEF = 32;

  // Operation field encodings
  typedef enum logic [1:0] {
    MIA_OP_ADDR   = 2'h0,
    MIA_OP_DATA   = 2'h1,
    MIA_OP_INC_RW = 2'h2,
    MIA_OP_INC_WR = 2'h3
  } mia_op_t;

  // One decoded management access
  typedef struct packed {
    logic                  acc;
    logic                  wr;
    logic [MIA_ADDR_W-1:0] addr;
    logic [MIA_REG_W-1:0]  wdata;
  } mia_req_t;

  // Answer to one access
  typedef struct packed {
    logic                 ack;
    logic [MIA_REG_W-1:0] rdata;
  } mia_rsp_t;

endpackage : mia_pkg

//--- testbench/mia_host.sv
/*
  Host model: issues single management accesses to the portal.
  Assumes an access is taken on a rising edge and answered one edge later.
*/
`timescale 1ns/100ps
module mia_host
  import mia_pkg::*;
(
  // Clock and answer
  input  wire logic     clk_i,
  input  wire mia_rsp_t rsp_i,
  // Access request
  output mia_req_t      req_o
);
  // Idle at time zero
  initial req_o = '0;

  // One access; released lines show inverted values, not the last ones
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    @(negedge clk_i);
    req_o = '{acc: 1'b1, wr: w, addr: a, wdata: d};
    @(negedge clk_i);
    q = rsp_i.rdata;
    ok = rsp_i.ack;
    req_o = '{acc: 1'b0, wr: ~w, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : mia_host

//--- testbench/mia_portal_tb.sv
/*
  Self-checking bench for the portal: host model drives accesses.
  Assumes default local window of device 1Fh, 32 words.
*/
`timescale 1ns/100ps
module mia_portal_tb
  import mia_pkg::*;
;
  logic        clk_i  = 1'b0;
  logic        nrst_i = 1'b0;
  logic        en     = 1'b1;
  logic [15:0] fz_q;
  logic        fz_ok;
  mia_req_t    req;
  mia_rsp_t    rsp;
  mia_op_t     op;
  logic [4:0]  dev;
  logic [15:0] radr;
  int          error_cnt = 0;
  int          checks = 0;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  mia_portal dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en), .req_i(req),
                    .rsp_o(rsp), .op_o(op), .dev_o(dev), .reg_addr_o(radr));
  mia_host host_u (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));

  // Compare with case equality so unknowns never match
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // Every access must be acknowledged; reads compared against e
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                     input logic [15:0] e);
    logic [15:0] q;
    logic        ok;
    host_u.xfer(w, a, d, q, ok);
    chk("ack", 16'h0001, {15'h0000, ok});
    if (!w) chk("rdata", e, q);
  endtask : acc

  // Short forms for the two portal registers
  task automatic wc(input logic [15:0] d); acc(1'b1, MIA_CTRL_ADDR, d, 16'h0000); endtask : wc
  task automatic wd(input logic [15:0] d); acc(1'b1, MIA_DATA_ADDR, d, 16'h0000); endtask : wd
  task automatic rc(input logic [15:0] e); acc(1'b0, MIA_CTRL_ADDR, 16'h0000, e); endtask : rc
  task automatic rd(input logic [15:0] e); acc(1'b0, MIA_DATA_ADDR, 16'h0000, e); endtask : rd

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Watchdog, far beyond the roughly one hundred cycles the tests need
  initial begin
    #(4000 * 50);
    error_cnt++;
    complete_run();
  end

  // Test sequence
  initial begin
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    rc(16'h0000);
    rd(16'h0000);
    $display("test reset done");
    // Single indirect write, then no-increment reads
    wc(16'h001F);
    wd(16'h0000);
    wc(16'h401F);
    wd(16'h0001);
    rd(16'h0001);
    rd(16'h0001);
    chk("dev", 16'h001F, {11'h000, dev});
    wc(16'h001F);
    rd(16'h0000);
    $display("test single done");
    // Write-only increment mode
    wd(16'h0019);
    wc(16'hC01F);
    wd(16'hA000);
    wd(16'hA001);
    wd(16'hA002);
    rd(16'h0000);
    rd(16'h0000);
    wc(16'h001F);
    rd(16'h001C);
    $display("test write increment done");
    // Burst read with increment on reads and writes
    wd(16'h0019);
    wc(16'h801F);
    rd(16'hA000);
    rd(16'hA001);
    rd(16'hA002);
    chk("reg_addr", 16'h001C, radr);
    wd(16'hB000);
    wc(16'h001F);
    rd(16'h001D);
    $display("test burst done");
    // Unimplemented word still increments; other device reads zero
    wd(16'h0020);
    wc(16'h801F);
    rd(16'h0000);
    wc(16'h001F);
    rd(16'h0021);
    wd(16'h0000);
    wc(16'h4005);
    chk("op", 16'h0001, {14'h0000, op});
    wd(16'h1234);
    rd(16'h0000);
    wc(16'h401F);
    rd(16'h0001);
    acc(1'b1, 5'h0F, 16'hFFFF, 16'h0000);
    acc(1'b0, 5'h03, 16'h0000, 16'h0000);
    rc(16'h401F);
    $display("test unimplemented done");
    // Enable low: the access is ignored and the last answer stands
    @(negedge clk_i);
    en = 1'b0;
    host_u.xfer(1'b1, MIA_CTRL_ADDR, 16'h0000, fz_q, fz_ok);
    chk("frozen ack", 16'h0000, {15'h0000, fz_ok});
    chk("frozen rdata", 16'h401F, fz_q);
    en = 1'b1;
    rc(16'h401F);
    $display("test enable done");
    complete_run();
  end
endmodule : mia_portal_tb
